// ### common/pfc_pkg.sv
// Package: register map, field layout, reset values and bus responses of the prefetch cache control
package pfc_pkg;
  // Register byte offsets (AXI4-Lite, one aligned word each)
  localparam logic [7:0] OFF_CONTROL  = 8'h00;
  localparam logic [7:0] OFF_ACCESS   = 8'h10;
  localparam logic [7:0] OFF_TAG      = 8'h20;
  localparam logic [7:0] OFF_MASK     = 8'h30;
  localparam logic [7:0] OFF_WORD0    = 8'h40;
  localparam logic [7:0] OFF_WORD1    = 8'h50;
  localparam logic [7:0] OFF_WORD2    = 8'h60;
  localparam logic [7:0] OFF_WORD3    = 8'h70;
  localparam logic [7:0] OFF_REPL     = 8'h80;
  // Control register fields
  localparam int CTL_COH_BIT   = 16;
  localparam int CTL_DCNT_LSB  = 8;
  localparam int CTL_PREF_LSB  = 4;
  localparam int CTL_WS_LSB    = 0;
  localparam logic [2:0] WS_RESET = 3'h7;
  // Access register fields
  localparam int ACC_WEN_BIT   = 31;
  localparam int ACC_IDX_LSB   = 0;
  // Tag register fields
  localparam int TAG_BOOT_BIT  = 31;
  localparam int TAG_ADDR_LSB  = 4;
  localparam int TAG_VALID_BIT = 3;
  localparam int TAG_LOCK_BIT  = 2;
  localparam int TAG_KIND_BIT  = 1;
  // Mask register field and the two maskable lines
  localparam int MSK_LSB       = 5;
  localparam logic [3:0] MASK_LINE_A = 4'hA;
  localparam logic [3:0] MASK_LINE_B = 4'hB;
  // Flash region bases
  localparam logic [31:0] MAIN_BASE = 32'h1D000000;
  localparam logic [31:0] BOOT_BASE = 32'h1FC00000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Unused width constant; the replacement state is 15 bits
  localparam int REPL_W = 25;
endpackage

// ### src/pfc_cache_ctrl.sv
// Prefetch cache control, line maintenance and line fill logic
// What this block does
// - Flash programming invalidates lines per coherency bit
// - Data line count allocates 4/2/1/0 lines
// - Changing data line count invalidates all lines
// - Prefetch region select drives prefetchMode output only
// - Wait states zero to seven, reset seven
// - Line writes only when write enable set
// - Line index selects maintained line
// - Boot region bit chooses flash base
// - Hit by comparing 20-bit tag with address
// - Only valid lines hit; valid resets zero
// - Locked lines never replaced
// - Kind bit instruction/data, resets to instruction
// - Set mask bits force tag match
// - Mask writable only for lines 0x0A, 0x0B
// - Four data words of indexed line accessible
// - Data words unreadable under code protection
// - Read-only 15-bit replacement state, resets zero
`timescale 1ns/1ps
module pfc_cache_ctrl #(
  parameter int LINES = 16
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // AXI4-Lite write address/data/response
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address/data
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Core fetch port
  input  wire logic        fetchReq,
  input  wire logic [31:0] fetchAddr,
  input  wire logic        fetchIsData,
  input  wire logic        fetchCacheable,
  output logic             fetchHit,
  output logic             fetchDone,
  output logic [31:0]      fetchData,
  // Program flash port (16-byte parallel read)
  output logic             flashReq,
  output logic [31:0]      flashAddr,
  input  wire logic [127:0] flashData,
  // System events and status
  input  wire logic        flashProgramCycle,
  input  wire logic        codeProtected,
  output logic [1:0]       prefetchMode,
  output logic [2:0]       flashWaitStates
);
  if (LINES != 16) begin
    $error("pfc_cache_ctrl supports 16 lines only");
  end

  typedef enum logic [1:0] {FS_IDLE, FS_WAIT, FS_DONE} pfc_fill_e;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic        cohAll_reg, cohAll_next;
  logic [1:0]  dataCnt_reg, dataCnt_next;
  logic [1:0]  prefSel_reg, prefSel_next;
  logic [2:0]  waitSt_reg, waitSt_next;
  logic        lineWen_reg, lineWen_next;
  logic [3:0]  lineIdx_reg, lineIdx_next;
  logic [15:0] valid_reg, valid_next;
  logic [15:0] lock_reg, lock_next;
  logic [15:0] kind_reg, kind_next;
  logic [15:0] boot_reg, boot_next;
  logic [19:0] tagAddr_reg [16];
  logic [19:0] tagAddr_next [16];
  logic [10:0] mask_reg [2];
  logic [10:0] mask_next [2];
  logic [31:0] words_reg [16][4];
  logic [31:0] words_next [16][4];
  logic [14:0] plru_reg, plru_next;
  pfc_fill_e   fill_reg, fill_next;
  logic [2:0]  wsCnt_reg, wsCnt_next;
  logic [3:0]  victim_reg, victim_next;
  logic [31:0] fAddr_reg, fAddr_next;
  // Bus and fetch answer state
  logic        awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
  logic [7:0]  awAddr_reg, awAddr_next;
  logic [31:0] wData_reg, wData_next;
  logic [3:0]  wStrb_reg, wStrb_next;
  logic        bValid_reg, bValid_next, rValid_reg, rValid_next;
  logic [1:0]  bResp_reg, bResp_next, rResp_reg, rResp_next;
  logic [31:0] rData_reg, rData_next;
  logic        hit_reg, hit_next, done_reg, done_next;
  logic [31:0] fData_reg, fData_next;

  // ------------------------------------------------------------
  // Hit detection and victim choice
  // ------------------------------------------------------------
  logic [15:0] hitVec;
  logic [3:0]  hitIdx;
  logic        anyHit;
  logic [15:0] allowed;
  logic [3:0]  victim;
  logic        victimOk;
  logic [19:0] cmpMask;
  logic [31:0] base;

  // Tag compare per line; masked lines use their mask bits
  always_comb begin
    hitVec = '0;
    hitIdx = '0;
    anyHit = 1'b0;
    for (int i = 0; i < 16; i++) begin
      cmpMask = '1;
      if (i == 10) cmpMask[11:1] = ~mask_reg[0];
      if (i == 11) cmpMask[11:1] = ~mask_reg[1];
      base = boot_reg[i] ? pfc_pkg::MAIN_BASE : pfc_pkg::BOOT_BASE;
      if (valid_reg[i] && (fetchAddr[31:24] == base[31:24]) &&
          (((fetchAddr[23:4] ^ tagAddr_reg[i]) & cmpMask) == '0) &&
          (kind_reg[i] == !fetchIsData)) begin
        hitVec[i] = 1'b1;
      end
    end
    for (int i = 15; i >= 0; i--) begin
      if (hitVec[i]) begin
        hitIdx = 4'(i);
        anyHit = 1'b1;
      end
    end
  end

  // Data lines are the top lines; count 11/10/01/00 gives 4/2/1/0
  always_comb begin
    allowed = '0;
    for (int i = 0; i < 16; i++) begin
      if (fetchIsData) begin
        case (dataCnt_reg)
          2'h3:    allowed[i] = (i >= 12);
          2'h2:    allowed[i] = (i >= 14);
          2'h1:    allowed[i] = (i == 15);
          default: allowed[i] = 1'b0;
        endcase
      end else begin
        case (dataCnt_reg)
          2'h3:    allowed[i] = (i < 12);
          2'h2:    allowed[i] = (i < 14);
          2'h1:    allowed[i] = (i < 15);
          default: allowed[i] = 1'b1;
        endcase
      end
      if (lock_reg[i]) allowed[i] = 1'b0;
    end
  end

  // Tree pseudo-LRU walk, falling back to first allowed line
  always_comb begin
    logic [3:0] node;
    node = 4'h0;
    victim = '0;
    victimOk = 1'b0;
    for (int l = 0; l < 4; l++) begin
      victim[3 - l] = plru_reg[(1 << l) - 1 + int'(node)];
      node = {node[2:0], victim[3 - l]};
    end
    victimOk = allowed[victim];
    for (int i = 15; i >= 0; i--) begin
      if (!victimOk && allowed[i]) victim = 4'(i);
    end
    victimOk = |allowed;
  end

  // ------------------------------------------------------------
  // Next state: registers, bus, fill
  // ------------------------------------------------------------
  logic doWrite, doRead, rdErr, wrErr, cfgChange;
  logic [31:0] rdVal;
  logic [31:0] wMerged;
  logic [31:0] cur;
  logic [1:0]  mSel;

  always_comb begin
    cohAll_next = cohAll_reg; dataCnt_next = dataCnt_reg;
    prefSel_next = prefSel_reg; waitSt_next = waitSt_reg;
    lineWen_next = lineWen_reg; lineIdx_next = lineIdx_reg;
    valid_next = valid_reg; lock_next = lock_reg;
    kind_next = kind_reg; boot_next = boot_reg;
    tagAddr_next = tagAddr_reg; mask_next = mask_reg; words_next = words_reg;
    plru_next = plru_reg; fill_next = fill_reg; wsCnt_next = wsCnt_reg;
    victim_next = victim_reg; fAddr_next = fAddr_reg;
    awHeld_next = awHeld_reg; wHeld_next = wHeld_reg;
    awAddr_next = awAddr_reg; wData_next = wData_reg; wStrb_next = wStrb_reg;
    bValid_next = bValid_reg; bResp_next = bResp_reg;
    rValid_next = rValid_reg; rResp_next = rResp_reg; rData_next = rData_reg;
    hit_next = 1'b0; done_next = 1'b0; fData_next = fData_reg;
    cfgChange = 1'b0; wrErr = 1'b0; rdErr = 1'b0; rdVal = '0; cur = '0;
    mSel = 2'h0;

    // Address and data are held until both arrive
    if (s_axi_awvalid && !awHeld_reg) begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld_reg) begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    doWrite = awHeld_reg && wHeld_reg && !bValid_reg;
    doRead  = s_axi_arvalid && !rValid_reg;

    // Current value of the addressed write target, for byte merges
    case (awAddr_reg)
      pfc_pkg::OFF_CONTROL: cur = {15'h0, cohAll_reg, 6'h0, dataCnt_reg, 2'h0,
                                   prefSel_reg, 1'b0, waitSt_reg};
      pfc_pkg::OFF_ACCESS:  cur = {lineWen_reg, 27'h0, lineIdx_reg};
      pfc_pkg::OFF_WORD0:   cur = words_reg[lineIdx_reg][0];
      pfc_pkg::OFF_WORD1:   cur = words_reg[lineIdx_reg][1];
      pfc_pkg::OFF_WORD2:   cur = words_reg[lineIdx_reg][2];
      pfc_pkg::OFF_WORD3:   cur = words_reg[lineIdx_reg][3];
      default:              cur = '0;
    endcase
    for (int b = 0; b < 4; b++) begin
      wMerged[b*8 +: 8] = wStrb_reg[b] ? wData_reg[b*8 +: 8] : cur[b*8 +: 8];
    end

    // Register write; unimplemented bits are simply dropped
    if (doWrite) begin
      awHeld_next = 1'b0;
      wHeld_next = 1'b0;
      bValid_next = 1'b1;
      case (awAddr_reg)
        pfc_pkg::OFF_CONTROL: begin
          cohAll_next  = wMerged[pfc_pkg::CTL_COH_BIT];
          dataCnt_next = wMerged[pfc_pkg::CTL_DCNT_LSB +: 2];
          prefSel_next = wMerged[pfc_pkg::CTL_PREF_LSB +: 2];
          waitSt_next  = wMerged[pfc_pkg::CTL_WS_LSB +: 3];
          cfgChange = (wMerged[pfc_pkg::CTL_DCNT_LSB +: 2] != dataCnt_reg);
        end
        pfc_pkg::OFF_ACCESS: begin
          lineWen_next = wMerged[pfc_pkg::ACC_WEN_BIT];
          lineIdx_next = wMerged[pfc_pkg::ACC_IDX_LSB +: 4];
        end
        pfc_pkg::OFF_TAG: begin
          if (lineWen_reg) begin
            boot_next[lineIdx_reg]    = wData_reg[pfc_pkg::TAG_BOOT_BIT];
            tagAddr_next[lineIdx_reg] = wData_reg[pfc_pkg::TAG_ADDR_LSB +: 20];
            valid_next[lineIdx_reg]   = wData_reg[pfc_pkg::TAG_VALID_BIT];
            lock_next[lineIdx_reg]    = wData_reg[pfc_pkg::TAG_LOCK_BIT];
            kind_next[lineIdx_reg]    = wData_reg[pfc_pkg::TAG_KIND_BIT];
          end
        end
        pfc_pkg::OFF_MASK: begin
          mSel = (lineIdx_reg == pfc_pkg::MASK_LINE_B) ? 2'h1 : 2'h0;
          if (lineWen_reg && (lineIdx_reg == pfc_pkg::MASK_LINE_A ||
                              lineIdx_reg == pfc_pkg::MASK_LINE_B)) begin
            mask_next[mSel[0]] = wData_reg[pfc_pkg::MSK_LSB +: 11];
          end
        end
        pfc_pkg::OFF_WORD0, pfc_pkg::OFF_WORD1,
        pfc_pkg::OFF_WORD2, pfc_pkg::OFF_WORD3: begin
          if (lineWen_reg) begin
            words_next[lineIdx_reg][awAddr_reg[5:4]] = wMerged;
          end
        end
        pfc_pkg::OFF_REPL: ;
        default: wrErr = 1'b1;
      endcase
      bResp_next = wrErr ? pfc_pkg::RESP_SLVERR : pfc_pkg::RESP_OKAY;
    end
    if (bValid_reg && s_axi_bready) bValid_next = 1'b0;

    // Register read
    if (doRead) begin
      case (s_axi_araddr)
        pfc_pkg::OFF_CONTROL: rdVal = {15'h0, cohAll_reg, 6'h0, dataCnt_reg, 2'h0,
                                       prefSel_reg, 1'b0, waitSt_reg};
        pfc_pkg::OFF_ACCESS:  rdVal = {lineWen_reg, 27'h0, lineIdx_reg};
        pfc_pkg::OFF_TAG:     rdVal = {boot_reg[lineIdx_reg], 7'h0, tagAddr_reg[lineIdx_reg],
                                       valid_reg[lineIdx_reg], lock_reg[lineIdx_reg],
                                       kind_reg[lineIdx_reg], 1'b0};
        pfc_pkg::OFF_MASK: begin
          if (lineIdx_reg == pfc_pkg::MASK_LINE_A) rdVal = {16'h0, mask_reg[0], 5'h0};
          if (lineIdx_reg == pfc_pkg::MASK_LINE_B) rdVal = {16'h0, mask_reg[1], 5'h0};
        end
        pfc_pkg::OFF_WORD0, pfc_pkg::OFF_WORD1,
        pfc_pkg::OFF_WORD2, pfc_pkg::OFF_WORD3: begin
          // Protected parts read zero so flash contents cannot leak
          rdVal = codeProtected ? 32'h0 : words_reg[lineIdx_reg][s_axi_araddr[5:4]];
        end
        pfc_pkg::OFF_REPL: rdVal = {17'h0, plru_reg};
        default: rdErr = 1'b1;
      endcase
      rValid_next = 1'b1;
      rData_next = rdVal;
      rResp_next = rdErr ? pfc_pkg::RESP_SLVERR : pfc_pkg::RESP_OKAY;
    end
    if (rValid_reg && s_axi_rready) rValid_next = 1'b0;

    // Fetch path: hit answers next cycle, cacheable miss fills a line when one is allowed
    case (fill_reg)
      FS_IDLE: begin
        if (fetchReq && !done_reg && anyHit) begin  // Answer cycle never restarts a fetch
          hit_next = 1'b1;
          done_next = 1'b1;
          fData_next = words_reg[hitIdx][fetchAddr[3:2]];
          for (int l = 0; l < 4; l++) begin  // Point tree away from the hit
            plru_next[(1 << l) - 1 + int'(hitIdx >> (4 - l))] = ~hitIdx[3 - l];
          end
        end else if (fetchReq && !done_reg && fetchCacheable && victimOk) begin
          fill_next = FS_WAIT;
          wsCnt_next = waitSt_reg;
          victim_next = victim;
          fAddr_next = {fetchAddr[31:4], 4'h0};
        end else if (fetchReq && !done_reg) begin
          fill_next = FS_WAIT;  // Uncached access still pays the wait states
          wsCnt_next = waitSt_reg;
          victim_next = 4'h0;
          fAddr_next = {fetchAddr[31:4], 4'h0};
        end
      end
      FS_WAIT: begin
        if (wsCnt_reg == 3'h0) fill_next = FS_DONE;
        else wsCnt_next = wsCnt_reg - 3'h1;
      end
      FS_DONE: begin
        fill_next = FS_IDLE;
        done_next = 1'b1;
        fData_next = flashData[fetchAddr[3:2]*32 +: 32];
        if (fetchCacheable && victimOk) begin
          for (int w = 0; w < 4; w++) words_next[victim_reg][w] = flashData[w*32 +: 32];
          tagAddr_next[victim_reg] = fAddr_reg[23:4];
          boot_next[victim_reg] = (fAddr_reg[31:24] == pfc_pkg::MAIN_BASE[31:24]);
          valid_next[victim_reg] = 1'b1;
          kind_next[victim_reg] = !fetchIsData;
          for (int l = 0; l < 4; l++) begin
            plru_next[(1 << l) - 1 + int'(victim_reg >> (4 - l))] = ~victim_reg[3 - l];
          end
        end
      end
      default: fill_next = FS_IDLE;
    endcase

    // Invalidation has the last word over any fill or write
    if (cfgChange) valid_next = '0;
    if (flashProgramCycle) begin
      for (int i = 0; i < 16; i++) begin
        if (cohAll_reg || !kind_reg[i] || !lock_reg[i]) valid_next[i] = 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cohAll_reg <= 1'b0; dataCnt_reg <= 2'h0; prefSel_reg <= 2'h0;
      waitSt_reg <= pfc_pkg::WS_RESET;
      lineWen_reg <= 1'b0; lineIdx_reg <= 4'h0;
      valid_reg <= '0;
      lock_reg <= '0;
      kind_reg <= '1;
      boot_reg <= '0;
      for (int i = 0; i < 16; i++) begin
        tagAddr_reg[i] <= '0;
        for (int w = 0; w < 4; w++) words_reg[i][w] <= '0;
      end
      mask_reg[0] <= '0; mask_reg[1] <= '0;
      plru_reg <= '0;
      fill_reg <= FS_IDLE; wsCnt_reg <= 3'h0; victim_reg <= 4'h0; fAddr_reg <= '0;
      awHeld_reg <= 1'b0; wHeld_reg <= 1'b0; awAddr_reg <= '0;
      wData_reg <= '0; wStrb_reg <= '0;
      bValid_reg <= 1'b0; bResp_reg <= '0; rValid_reg <= 1'b0;
      rResp_reg <= '0; rData_reg <= '0;
      hit_reg <= 1'b0; done_reg <= 1'b0; fData_reg <= '0;
    end else begin
      cohAll_reg <= cohAll_next; dataCnt_reg <= dataCnt_next;
      prefSel_reg <= prefSel_next; waitSt_reg <= waitSt_next;
      lineWen_reg <= lineWen_next; lineIdx_reg <= lineIdx_next;
      valid_reg <= valid_next; lock_reg <= lock_next;
      kind_reg <= kind_next; boot_reg <= boot_next;
      tagAddr_reg <= tagAddr_next; words_reg <= words_next; mask_reg <= mask_next;
      plru_reg <= plru_next; fill_reg <= fill_next; wsCnt_reg <= wsCnt_next;
      victim_reg <= victim_next; fAddr_reg <= fAddr_next;
      awHeld_reg <= awHeld_next; wHeld_reg <= wHeld_next; awAddr_reg <= awAddr_next;
      wData_reg <= wData_next; wStrb_reg <= wStrb_next;
      bValid_reg <= bValid_next; bResp_reg <= bResp_next;
      rValid_reg <= rValid_next; rResp_reg <= rResp_next; rData_reg <= rData_next;
      hit_reg <= hit_next; done_reg <= done_next; fData_reg <= fData_next;
    end
  end

  // Outputs from flip-flops; flashReq is decoded from fill_reg
  assign s_axi_awready   = !awHeld_reg;
  assign s_axi_wready    = !wHeld_reg;
  assign s_axi_bvalid    = bValid_reg;
  assign s_axi_bresp     = bResp_reg;
  assign s_axi_arready   = !rValid_reg;
  assign s_axi_rvalid    = rValid_reg;
  assign s_axi_rdata     = rData_reg;
  assign s_axi_rresp     = rResp_reg;
  assign fetchHit        = hit_reg;
  assign fetchDone       = done_reg;
  assign fetchData       = fData_reg;
  assign flashReq        = (fill_reg == FS_WAIT);
  assign flashAddr       = fAddr_reg;
  assign prefetchMode    = prefSel_reg;
  assign flashWaitStates = waitSt_reg;
endmodule

// ### testbench/pfc_flash_model.sv
// Program flash model answering whole 16-byte rows
`timescale 1ns/1ps
module pfc_flash_model (
  // Clock
  input  wire logic         clk_sys,
  // Row request
  input  wire logic         flashReq,
  input  wire logic [31:0]  flashAddr,
  // Row data
  output logic      [127:0] flashData
);
  logic        held;
  logic [31:0] row;
  // Row stays readable one cycle past the request only
  always @(posedge clk_sys) held <= flashReq;
  // Each word mixes its row address with a word pattern; junk when released
  always_comb begin
    for (int w = 0; w < 4; w++) begin
      row = flashAddr ^ (32'(w) * 32'h11110000);
      flashData[32*w +: 32] = (flashReq || held) ? row : ~row;
    end
  end
endmodule

// ### testbench/pfc_cache_ctrl_checker.sv
// Checker: port-level properties of the prefetch cache control
`timescale 1ns/1ps
module pfc_cache_ctrl_checker (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_b,
  // Register bus
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_rresp,
  // Fetch and flash
  input wire logic        fetchHit,
  input wire logic        fetchDone,
  input wire logic        flashReq,
  input wire logic [31:0] flashAddr,
  input wire logic [2:0]  flashWaitStates
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic [3:0] reqRun_reg;
  logic [3:0] reqRun_next;
  // Length of the running flash request
  always_comb reqRun_next = flashReq ? reqRun_reg + 4'h1 : 4'h0;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) reqRun_reg <= 4'h0;
    else reqRun_reg <= reqRun_next;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  reset_state_a: assert property ($rose(rst_b) |-> flashWaitStates == 3'h7 && !fetchDone)
    else $error("wait states not seven after reset");
  wait_count_a: assert property ($fell(flashReq) |-> reqRun_reg == {1'h0, flashWaitStates} + 4'h1)
    else $error("flash request length differs from wait states plus one");
  fill_done_a: assert property ($fell(flashReq) |-> ##[0:1] fetchDone)
    else $error("no answer after line fill");
  hit_quiet_a: assert property (fetchHit |-> fetchDone && !$past(flashReq))
    else $error("hit answered with flash traffic");
  row_align_a: assert property (flashReq |-> flashAddr[3:0] == 4'h0)
    else $error("flash row address not 16-byte aligned");
  row_hold_a: assert property (flashReq && $past(flashReq) |-> $stable(flashAddr))
    else $error("flash address moved during request");
  done_pulse_a: assert property (fetchDone |=> !fetchDone)
    else $error("answer longer than one cycle");
  read_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer held after it was taken");
  // Main scenarios reached
  cover property (fetchHit);
  cover property ($fell(flashReq));
  cover property (s_axi_rvalid && s_axi_rresp == pfc_pkg::RESP_SLVERR);
endmodule

// ### testbench/pfc_cache_ctrl_test.sv
// Testbench: registers, line maintenance and fetches of the prefetch cache control
`timescale 1ns/1ps
module pfc_cache_ctrl_test;
  logic         clk_sys = 1'h0, rst_b = 1'h0;
  logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata, fetchAddr = 32'h0, fetchData, flashAddr;
  logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, fetchReq = 1'h0, fetchIsData = 1'h0;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]   s_axi_bresp, s_axi_rresp, prefetchMode;
  logic         fetchHit, fetchDone, flashReq, flashProgramCycle = 1'h0, codeProtected = 1'h0;
  logic [127:0] flashData;
  logic [2:0]   flashWaitStates;
  logic         fetchCacheable = 1'h1;
  int           n_errors = 0, comparisons = 0, cycles = 0;
  localparam logic [1:0] OK = pfc_pkg::RESP_OKAY;
  // Clock and hang guard
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  pfc_cache_ctrl u_dut (.clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fetchReq, .fetchAddr, .fetchIsData, .fetchCacheable,
    .fetchHit, .fetchDone, .fetchData, .flashReq, .flashAddr, .flashData, .flashProgramCycle,
    .codeProtected, .prefetchMode, .flashWaitStates);
  pfc_flash_model u_flash (.clk_sys, .flashReq, .flashAddr, .flashData);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Unimplemented control bits always written as zero
  function automatic logic [31:0] ctl(input logic c, input logic [1:0] d, p, input logic [2:0] w);
    return {15'h0, c, 6'h0, d, 2'h0, p, 1'h0, w};
  endfunction
  function automatic logic [31:0] fw(input logic [31:0] a);
    return {a[31:4], 4'h0} ^ (32'(a[3:2]) * 32'h11110000);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (aw || w) begin
      @(posedge clk_sys);
      if (s_axi_awready) aw = 1'h0;
      if (s_axi_wready) w = 1'h0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge clk_sys); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    check({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    check(s_axi_rdata, exp);
    check({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge clk_sys);
  endtask
  task automatic fetch(input logic [31:0] a, input logic d, hit, input logic [31:0] exp);
    fetchAddr <= a;
    fetchIsData <= d;
    fetchReq <= 1'h1;
    do @(posedge clk_sys); while (!fetchDone);
    fetchReq <= 1'h0;
    check({31'h0, fetchHit}, {31'h0, hit});
    check(fetchData, exp);
    @(posedge clk_sys);
  endtask
  task automatic program_pulse();
    flashProgramCycle <= 1'h1;
    @(posedge clk_sys);
    flashProgramCycle <= 1'h0;
    @(posedge clk_sys);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(pfc_pkg::OFF_CONTROL, 32'h00000007, OK);
    rd(pfc_pkg::OFF_REPL, 32'h0, OK);
    rd(pfc_pkg::OFF_TAG, 32'h00000002, OK);
    rd(8'hF0, 32'h0, pfc_pkg::RESP_SLVERR);
    wr(8'hF0, 32'h0, pfc_pkg::RESP_SLVERR);
  endtask
  // Every data size and prefetch mode; size change also drops lines
  task automatic t_modes();
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      wr(pfc_pkg::OFF_CONTROL, ctl(1'h0, m, m, 3'h0), OK);
      rd(pfc_pkg::OFF_CONTROL, ctl(1'h0, m, m, 3'h0), OK);
      check({30'h0, prefetchMode}, {30'h0, m});
      fetch(32'h1D000044, 1'h1, 1'h0, fw(32'h1D000044));
      fetch(32'h1D000044, 1'h1, m != 2'h0, fw(32'h1D000044));
    end
    fetch(32'h1D000088, 1'h0, 1'h0, fw(32'h1D000088));
    fetch(32'h1D000088, 1'h0, 1'h1, fw(32'h1D000088));
    wr(pfc_pkg::OFF_CONTROL, ctl(1'h0, 2'h2, 2'h0, 3'h3), OK);
    fetch(32'h1D000088, 1'h0, 1'h0, fw(32'h1D000088));
  endtask
  task automatic t_lines();
    wr(pfc_pkg::OFF_ACCESS, 32'h80000005, OK);
    wr(pfc_pkg::OFF_TAG, 32'h8012345A, OK);
    for (int k = 0; k < 4; k++)
      wr(pfc_pkg::OFF_WORD0 + 8'(16 * k), 32'hC0DE0000 + 32'(k), OK);
    rd(pfc_pkg::OFF_TAG, 32'h8012345A, OK);
    for (int k = 0; k < 4; k++)
      rd(pfc_pkg::OFF_WORD0 + 8'(16 * k), 32'hC0DE0000 + 32'(k), OK);
    fetch(32'h1D123454, 1'h0, 1'h1, 32'hC0DE0001);
    wr(pfc_pkg::OFF_ACCESS, 32'h00000005, OK);
    wr(pfc_pkg::OFF_WORD1, 32'h0BAD0BAD, OK);
    rd(pfc_pkg::OFF_WORD1, 32'hC0DE0001, OK);
    codeProtected <= 1'h1;
    rd(pfc_pkg::OFF_WORD1, 32'h0, OK);
    codeProtected <= 1'h0;
    fetchCacheable <= 1'h0;
    fetch(32'h1D000200, 1'h0, 1'h0, fw(32'h1D000200));
    fetch(32'h1D000200, 1'h0, 1'h0, fw(32'h1D000200));
    fetchCacheable <= 1'h1;
  endtask
  task automatic t_mask();
    wr(pfc_pkg::OFF_ACCESS, 32'h8000000A, OK);
    wr(pfc_pkg::OFF_TAG, 32'h8012000E, OK);
    wr(pfc_pkg::OFF_WORD0, 32'hA0A0A0A0, OK);
    wr(pfc_pkg::OFF_MASK, 32'h0000FFE0, OK);
    rd(pfc_pkg::OFF_MASK, 32'h0000FFE0, OK);
    fetch(32'h1D12FFE0, 1'h0, 1'h1, 32'hA0A0A0A0);
    wr(pfc_pkg::OFF_ACCESS, 32'h80000005, OK);
    wr(pfc_pkg::OFF_MASK, 32'h0000FFE0, OK);
    rd(pfc_pkg::OFF_MASK, 32'h0, OK);
    program_pulse();
    fetch(32'h1D123454, 1'h0, 1'h0, fw(32'h1D123454));
    fetch(32'h1D12FFE0, 1'h0, 1'h1, 32'hA0A0A0A0);
    wr(pfc_pkg::OFF_CONTROL, ctl(1'h1, 2'h2, 2'h0, 3'h3), OK);
    program_pulse();
    fetch(32'h1D12FFE0, 1'h0, 1'h0, fw(32'h1D12FFE0));
  endtask
  // Reset, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'h1;
    @(posedge clk_sys);
    t_reset();
    t_modes();
    t_lines();
    t_mask();
    finish_test();
  end
endmodule
bind pfc_cache_ctrl pfc_cache_ctrl_checker u_chk (.clk_sys, .rst_b, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rresp, .fetchHit, .fetchDone, .flashReq, .flashAddr,
  .flashWaitStates);
